/* design/fss_bank.sv */
`timescale 1ns/1ps

// Behaviour
// - Limit bits 15:11 exponent, RW, reset zero
// - Limit bits 10:0 mantissa, RW, reset 019h
// - Summary byte is the word's low byte
// - Code 79h returns two-byte fault summary
// - Alert on every event except input undervoltage
// - Busy bit always reads zero
// - Off bit live: one while output unpowered
// - Bit 5 latches output overvoltage fault
// - Bit 4 latches output overcurrent fault
// - Bit 3 latches input below undervoltage lockout
// - Bit 2 latches over-temperature fault or warning
// - Bit 1 latches communication, memory, logic fault
// - Word bit 13 latches input fault/warning
module fss_bank (
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Decoded command port from the bus engine
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [15:0] cmd_wdata_in,
  input wire logic clear_faults_in,
  output logic rsp_valid_out,
  output logic rsp_ack_out,
  output logic [15:0] rsp_rdata_out,
  // Detector inputs, high while the condition is present
  input wire logic output_off_in,
  input wire logic power_good_in,
  input wire logic output_overvoltage_flag_in,
  input wire logic output_overcurrent_flag_in,
  input wire logic input_undervoltage_flag_in,
  input wire logic over_temp_fault_in,
  input wire logic over_temp_warning_in,
  input wire logic comm_memory_logic_flag_in,
  input wire logic output_undervoltage_fault_in,
  input wire logic overcurrent_warning_in,
  input wire logic input_fault_warning_in,
  input wire logic mfr_fault_in,
  // Limit handed to the input current comparator
  output logic [4:0] warn_limit_exponent_out,
  output logic [10:0] warn_limit_mantissa_out,
  // Open-drain alert pin: driven low while oe is high
  output logic bus_alert_output_n_out,
  output logic bus_alert_output_oe_out
);

  fss_pkg::fss_state_s s_q;
  fss_pkg::fss_state_s s_d;
  logic [15:0] word;
  logic cmd_read;
  logic cmd_limit;
  logic cmd_byte;
  logic cmd_word;
  logic bad_cmd;
  logic clr;
  logic ev_ov;
  logic ev_oc;
  logic ev_uv;
  logic ev_temp;
  logic ev_cml;
  logic ev_other;
  logic ev_vout;
  logic ev_iout;
  logic ev_input;
  logic ev_mfr;
  logic ev_alert;

  // ----------------------------------------------------------------
  // Summary word assembly
  // ----------------------------------------------------------------
  always_comb begin
    word = fss_pkg::WORD_RESET;
    word[fss_pkg::BIT_VOUT] = s_q.vout;
    word[fss_pkg::BIT_IOUT] = s_q.iout;
    word[fss_pkg::BIT_INPUT] = s_q.input_f;
    word[fss_pkg::BIT_MFR] = s_q.mfr;
    word[fss_pkg::BIT_PGOOD] = ~power_good_in;
    word[fss_pkg::BIT_BUSY] = 1'b0;
    word[fss_pkg::BIT_OFF] = output_off_in;
    word[fss_pkg::BIT_OV] = s_q.ov;
    word[fss_pkg::BIT_OC] = s_q.oc;
    word[fss_pkg::BIT_UV] = s_q.uv;
    word[fss_pkg::BIT_TEMP] = s_q.temp;
    word[fss_pkg::BIT_CML] = s_q.comm_memory_logic_flag;
    word[fss_pkg::BIT_OTHER] = s_q.other;
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  always_comb begin
    cmd_read = cmd_valid_in && !cmd_write_in;
    cmd_limit = 1'b0;
    cmd_byte = 1'b0;
    cmd_word = 1'b0;
    bad_cmd = 1'b0;
    if (cmd_code_in == fss_pkg::CMD_WARN_LIMIT) begin
      cmd_limit = cmd_valid_in;
    end else if (cmd_code_in == fss_pkg::CMD_SUMMARY_BYTE) begin
      cmd_byte = cmd_read;
      bad_cmd = cmd_valid_in && cmd_write_in;
    end else if (cmd_code_in == fss_pkg::CMD_SUMMARY_WORD) begin
      cmd_word = cmd_read;
      bad_cmd = cmd_valid_in && cmd_write_in;
    end else begin
      // Unknown codes and writes to read-only summaries count as communication faults
      bad_cmd = cmd_valid_in;
    end
  end

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  always_comb begin
    ev_ov = output_overvoltage_flag_in;
    ev_oc = output_overcurrent_flag_in;
    ev_uv = input_undervoltage_flag_in;
    ev_temp = over_temp_fault_in || over_temp_warning_in;
    ev_cml = comm_memory_logic_flag_in || bad_cmd;
    ev_other = output_undervoltage_fault_in || overcurrent_warning_in ||
      input_fault_warning_in || mfr_fault_in;
    ev_vout = ev_ov || output_undervoltage_fault_in;
    ev_iout = ev_oc || overcurrent_warning_in;
    ev_input = ev_uv || input_fault_warning_in;
    ev_mfr = mfr_fault_in;
    // Input undervoltage reaches only ev_uv and ev_input, so it never raises the pin
    ev_alert = ev_vout || ev_iout || ev_temp || ev_cml || ev_other;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    clr = clear_faults_in;
    s_d.rvalid = cmd_valid_in;
    s_d.rack = cmd_valid_in && !bad_cmd;
    // Writes and refused commands answer with zero data
    if (cmd_valid_in) begin
      s_d.rdata = 16'h0000;
    end
    if (cmd_limit && cmd_write_in) begin
      s_d.exp = cmd_wdata_in[fss_pkg::EXP_MSB:fss_pkg::EXP_LSB];
      s_d.man = cmd_wdata_in[fss_pkg::MAN_MSB:fss_pkg::MAN_LSB];
    end
    if (cmd_limit && !cmd_write_in) begin
      s_d.rdata = {s_q.exp, s_q.man};
    end
    if (cmd_byte) begin
      s_d.rdata = {8'h00, word[7:0]};
    end
    if (cmd_word) begin
      s_d.rdata = word;
    end
    // Clear first, then sets, so an event in the clearing cycle survives
    if (clr) begin
      s_d.vout = 1'b0;
      s_d.iout = 1'b0;
      s_d.input_f = 1'b0;
      s_d.mfr = 1'b0;
      s_d.ov = 1'b0;
      s_d.oc = 1'b0;
      s_d.uv = 1'b0;
      s_d.temp = 1'b0;
      s_d.comm_memory_logic_flag = 1'b0;
      s_d.other = 1'b0;
      s_d.alert = 1'b0;
    end
    if (ev_ov) begin
      s_d.ov = 1'b1;
    end
    if (ev_oc) begin
      s_d.oc = 1'b1;
    end
    if (ev_uv) begin
      s_d.uv = 1'b1;
    end
    if (ev_temp) begin
      s_d.temp = 1'b1;
    end
    if (ev_cml) begin
      s_d.comm_memory_logic_flag = 1'b1;
    end
    if (ev_other) begin
      s_d.other = 1'b1;
    end
    if (ev_vout) begin
      s_d.vout = 1'b1;
    end
    if (ev_iout) begin
      s_d.iout = 1'b1;
    end
    if (ev_input) begin
      s_d.input_f = 1'b1;
    end
    if (ev_mfr) begin
      s_d.mfr = 1'b1;
    end
    if (ev_alert) begin
      s_d.alert = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= '0;
      s_q.exp <= fss_pkg::EXP_RESET;
      s_q.man <= fss_pkg::MAN_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign rsp_valid_out = s_q.rvalid;
  assign rsp_ack_out = s_q.rack;
  assign rsp_rdata_out = s_q.rdata;
  assign warn_limit_exponent_out = s_q.exp;
  assign warn_limit_mantissa_out = s_q.man;
  assign bus_alert_output_n_out = ~s_q.alert;
  assign bus_alert_output_oe_out = s_q.alert;

endmodule

/* design/fss_pkg.sv */
package fss_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_WARN_LIMIT = 8'h5d;
  localparam logic [7:0] CMD_SUMMARY_BYTE = 8'h78;
  localparam logic [7:0] CMD_SUMMARY_WORD = 8'h79;

  // ----------------------------------------------------------------
  // Input overcurrent warning limit layout
  // ----------------------------------------------------------------
  localparam int EXP_MSB = 15;
  localparam int EXP_LSB = 11;
  localparam int MAN_MSB = 10;
  localparam int MAN_LSB = 0;
  localparam logic [4:0] EXP_RESET = 5'h00;
  localparam logic [10:0] MAN_RESET = 11'h019;

  // ----------------------------------------------------------------
  // Summary word bit positions
  // ----------------------------------------------------------------
  localparam int BIT_VOUT = 15;
  localparam int BIT_IOUT = 14;
  localparam int BIT_INPUT = 13;
  localparam int BIT_MFR = 12;
  localparam int BIT_PGOOD = 11;
  localparam int BIT_BUSY = 7;
  localparam int BIT_OFF = 6;
  localparam int BIT_OV = 5;
  localparam int BIT_OC = 4;
  localparam int BIT_UV = 3;
  localparam int BIT_TEMP = 2;
  localparam int BIT_CML = 1;
  localparam int BIT_OTHER = 0;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // State of the bank
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] exp;
    logic [10:0] man;
    logic vout;
    logic iout;
    logic input_f;
    logic mfr;
    logic ov;
    logic oc;
    logic uv;
    logic temp;
    logic comm_memory_logic_flag;
    logic other;
    logic alert;
    logic [15:0] rdata;
    logic rvalid;
    logic rack;
  } fss_state_s;

endpackage

/* tb/fss_bank_props.sv */
`timescale 1ns/1ps

module fss_bank_props (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [15:0] cmd_wdata_in,
  input wire logic clear_faults_in,
  input wire logic output_off_in,
  input wire logic output_overvoltage_flag_in,
  input wire logic rsp_valid_out,
  input wire logic rsp_ack_out,
  input wire logic [15:0] rsp_rdata_out,
  input wire logic [4:0] warn_limit_exponent_out,
  input wire logic [10:0] warn_limit_mantissa_out,
  input wire logic bus_alert_output_n_out,
  input wire logic bus_alert_output_oe_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  rsp_follows_a: assert property (cmd_valid_in |=> rsp_valid_out) else $error("no response");
  rsp_alone_a: assert property (!cmd_valid_in |=> !rsp_valid_out) else $error("stray response");
  busy_zero_a: assert property (cmd_valid_in && cmd_code_in != 8'h5d |=> !rsp_rdata_out[7])
    else $error("busy bit set");
  byte_high_a: assert property (rsp_valid_out && $past(cmd_code_in) == 8'h78 |-> rsp_rdata_out[15:8] == 8'h00)
    else $error("byte read high");
  off_live_a: assert property (cmd_valid_in && !cmd_write_in && cmd_code_in == 8'h79
    |=> rsp_rdata_out[6] == $past(output_off_in)) else $error("off bit wrong");
  ov_alert_a: assert property (output_overvoltage_flag_in
    |=> bus_alert_output_oe_out && !bus_alert_output_n_out) else $error("no alert on ov");
  alert_hold_a: assert property (bus_alert_output_oe_out && !clear_faults_in |=> bus_alert_output_oe_out)
    else $error("alert dropped");
  limit_write_a: assert property (cmd_valid_in && cmd_write_in && cmd_code_in == 8'h5d
    |=> {warn_limit_exponent_out, warn_limit_mantissa_out} == $past(cmd_wdata_in)) else $error("limit");
  pin_pair_a: assert property (bus_alert_output_oe_out != bus_alert_output_n_out) else $error("pin pair");
  cover property (rsp_valid_out && !rsp_ack_out);
  cover property ($rose(bus_alert_output_oe_out));
  cover property (cmd_valid_in && cmd_write_in);
endmodule

bind fss_bank fss_bank_props PROPS (.*);

/* tb/fss_host.sv */
`timescale 1ns/1ps

// Host side: one command per call, released code and data lines show the inverse
module fss_host (
  input wire logic core_clk_in,
  input wire logic rsp_valid_in,
  input wire logic rsp_ack_in,
  input wire logic [15:0] rsp_rdata_in,
  output logic cmd_valid_out = 1'b0,
  output logic cmd_write_out = 1'b0,
  output logic [7:0] cmd_code_out = 8'h00,
  output logic [15:0] cmd_wdata_out = 16'h0000
);
  task xfer(input logic w, input logic [7:0] c, input logic [15:0] d, output logic [15:0] q, output logic a);
    @(negedge core_clk_in);
    cmd_valid_out = 1'b1;
    cmd_write_out = w;
    cmd_code_out = c;
    cmd_wdata_out = d;
    @(negedge core_clk_in);
    cmd_valid_out = 1'b0;
    cmd_code_out = ~c;
    cmd_wdata_out = ~d;
    q = rsp_rdata_in;
    // A missing response shows as unknown so any compare fails
    a = (rsp_valid_in === 1'b1) ? rsp_ack_in : 1'bx;
  endtask
endmodule

/* tb/pmbus_fault_status_summary_bench.sv */
`timescale 1ns/1ps

module pmbus_fault_status_summary_bench;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic clear_faults_in = 1'b0;
  logic output_off_in = 1'b0;
  logic power_good_in = 1'b1;
  logic [9:0] det = 10'h000;
  logic cv, cw, rv, ra, an, aoe, ack;
  logic [7:0] cc;
  logic [15:0] cd, rd, got;
  logic [4:0] le;
  logic [10:0] lm;
  int n_mismatch = 0;
  int tests_run = 0;
  logic [15:0] tbl [10] = '{16'h8020, 16'h4010, 16'h2008, 16'h0004, 16'h0004, 16'h0002, 16'h8001, 16'h4001,
    16'h2001, 16'h1001};
  always #50 core_clk_in = ~core_clk_in;
  fss_host host (.core_clk_in(core_clk_in), .rsp_valid_in(rv), .rsp_ack_in(ra), .rsp_rdata_in(rd),
    .cmd_valid_out(cv), .cmd_write_out(cw), .cmd_code_out(cc), .cmd_wdata_out(cd));
  fss_bank DUT (.core_clk_in(core_clk_in), .rst_in(rst_in), .cmd_valid_in(cv), .cmd_write_in(cw),
    .cmd_code_in(cc), .cmd_wdata_in(cd), .clear_faults_in(clear_faults_in), .rsp_valid_out(rv),
    .rsp_ack_out(ra), .rsp_rdata_out(rd), .output_off_in(output_off_in), .power_good_in(power_good_in),
    .output_overvoltage_flag_in(det[0]), .output_overcurrent_flag_in(det[1]),
    .input_undervoltage_flag_in(det[2]), .over_temp_fault_in(det[3]), .over_temp_warning_in(det[4]),
    .comm_memory_logic_flag_in(det[5]), .output_undervoltage_fault_in(det[6]), .overcurrent_warning_in(det[7]),
    .input_fault_warning_in(det[8]), .mfr_fault_in(det[9]), .warn_limit_exponent_out(le),
    .warn_limit_mantissa_out(lm), .bus_alert_output_n_out(an), .bus_alert_output_oe_out(aoe));
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task rd_chk(input logic w, input logic [7:0] c, input logic [15:0] e, input logic ea);
    host.xfer(w, c, w ? e : 16'h0000, got, ack);
    chk("rdata", w ? 16'h0000 : e, got);
    chk("ack", {15'h0000, ea}, {15'h0000, ack});
  endtask
  task clear;
    @(negedge core_clk_in);
    clear_faults_in = 1'b1;
    @(negedge core_clk_in);
    clear_faults_in = 1'b0;
  endtask
  task finish_test;
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    repeat (10) @(negedge core_clk_in);
    rst_in = 1'b0;
    chk("limit", 16'h0019, {le, lm});
    output_off_in = 1'b1;
    power_good_in = 1'b0;
    rd_chk(1'b0, 8'h79, 16'h0840, 1'b1);
    output_off_in = 1'b0;
    power_good_in = 1'b1;
    rd_chk(1'b0, 8'h78, 16'h0000, 1'b1);
    rd_chk(1'b1, 8'h5d, 16'h8ad3, 1'b1);
    chk("limit", 16'h8ad3, {le, lm});
    rd_chk(1'b0, 8'h5d, 16'h8ad3, 1'b1);
    for (int i = 0; i < 10; i++) begin
      clear();
      det[i] = 1'b1;
      @(negedge core_clk_in);
      det = 10'h000;
      chk("alert", {15'h0000, i != 2}, {15'h0000, aoe});
      chk("alert_n", {15'h0000, i == 2}, {15'h0000, an});
      rd_chk(1'b0, 8'h79, tbl[i], 1'b1);
      rd_chk(1'b0, 8'h78, tbl[i] & 16'h00ff, 1'b1);
    end
    clear();
    chk("alert", 16'h0000, {15'h0000, aoe});
    rd_chk(1'b0, 8'h00, 16'h0000, 1'b0);
    rd_chk(1'b1, 8'h78, 16'hffff, 1'b0);
    rd_chk(1'b0, 8'h79, 16'h0002, 1'b1);
    // Clear and a new event in one cycle: the event must survive
    @(negedge core_clk_in);
    clear_faults_in = 1'b1;
    det[0] = 1'b1;
    @(negedge core_clk_in);
    clear_faults_in = 1'b0;
    det = 10'h000;
    rd_chk(1'b0, 8'h79, 16'h8020, 1'b1);
    finish_test();
  end
endmodule
